// ===== verilog/peripheral_interrupt_controller.v
// Notes on behaviour
// RULE1 - A peripheral event sets its flag regardless of the mask.
// RULE2 - Request only when flag, mask and interrupt-enable are all one.
// RULE3 - Writing one clears a flag; zero leaves it; read shows pending.
// RULE4 - Reset clears every factor flag.
// RULE5 - Watchdog request ignores masks and enable; it has no flag.
// RULE6 - Mask bits read and write; one allows, zero inhibits.
// RULE7 - Reset clears every mask bit.
// RULE8 - Each mask bit gates the flag at the same bit position.
// RULE9 - Timer channels two, one, zero set flag bits D2, D1, D0.
// RULE10 - Serial transfer completion sets serial flag D0.
// RULE11 - Key group edges set D0 of that group's flag register.
// RULE12 - Clock 1, 2, 8, 32 Hz falling edges set D3 to D0.
// RULE13 - Stopwatch run, lap, 1 Hz, 10 Hz set D3 to D0.
// RULE14 - Converter reference end sets D1; sensor end sets D0.
// RULE15 - Service starts only after the current instruction finishes.
// RULE16 - On acceptance the flags are saved, then interrupt-enable clears.
// RULE17 - The CPU pushes the next address onto the stack.
// RULE18 - The accepted request supplies the vector's low program bits.
// RULE19 - Fixed priority: watchdog, converter, timer, serial, keys, clock, stopwatch.
// RULE20 - The service routine clears its flag before re-enabling.
// RULE21 - Unimplemented mask and flag bits read zero, ignore writes.
// RULE22 - Any request, watchdog included, wakes the halted CPU.
// RULE23 - All requests blocked until both stack pointers are written.
// RULE24 - A group requests when any of its flag-and-mask bits is one.
// RULE25 - Highest-priority group's vector shown; lower ones stay pending.
`include "irq_ctrl_map.vh"
module peripheral_interrupt_controller
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire [17:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [2:0]  ptimer_zero_evt,
  input  wire        serial_done_evt,
  input  wire        key_group0_evt,
  input  wire        key_group1_evt,
  input  wire [3:0]  clock_timer_evt,
  input  wire [3:0]  stopwatch_evt,
  input  wire [1:0]  rf_conv_evt,
  input  wire        watchdog_req,
  input  wire        instr_done,
  input  wire        wide_sp_write,
  input  wire        nibble_sp_write,
  output wire        irq_req,
  output wire        nmi_req,
  output wire        wake_req,
  output reg  [15:0] vector_addr_r,
  output reg         irq_take_r,
  output reg         flags_save_r,
  output reg         push_pc_r
);

  // One-hot acceptance sequencer; SAVE and PUSH each last one enabled clock, IDLE lasts until take.
  localparam ST_IDLE = 3'b001;
  localparam ST_SAVE = 3'b010;
  localparam ST_PUSH = 3'b100;

  // Masks and flags are kept per group in priority order: index 0 is the
  // converter and index 6 the stopwatch.
  reg  [3:0] en_r   [0:6];
  reg  [3:0] pend_r [0:6];
  reg        ie_r;
  reg        wide_sp_ok_r;
  reg        nib_sp_ok_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [31:0] rdata_r;
  wire [3:0] evt    [0:6];
  wire [6:0] grp_req;
  wire       sp_ok;
  wire       wr_en;
  wire       rd_en;
  wire       hit;
  wire [2:0] sel;
  wire       sel_pend;
  wire       sel_ctl;
  wire       take;
  integer    i;

  // Group index 0..6 follows priority order after the watchdog.
  function [3:0] grp_bits;
    input [2:0] g;
    begin
      case (g)
        3'd0: grp_bits = `BITS_RF_CONV;
        3'd1: grp_bits = `BITS_PTIMER;
        3'd2: grp_bits = `BITS_SERIAL;
        3'd3: grp_bits = `BITS_KEYS;
        3'd4: grp_bits = `BITS_KEYS;
        3'd5: grp_bits = `BITS_CLOCK;
        default: grp_bits = `BITS_STOPWATCH;
      endcase
    end
  endfunction

  // Maps a printed offset low digit (1..7) to the priority-ordered group.
  function [2:0] grp_of;
    input [3:0] lo;
    begin
      case (lo)
        4'h1: grp_of = 3'd1;
        4'h2: grp_of = 3'd2;
        4'h3: grp_of = 3'd3;
        4'h4: grp_of = 3'd4;
        4'h5: grp_of = 3'd5;
        4'h6: grp_of = 3'd6;
        default: grp_of = 3'd0;
      endcase
    end
  endfunction

  // Watchdog first, then the groups in index order. With nothing pending
  // the stopwatch vector comes back, but the sequencer never latches it then.
  function [15:0] pick_vector;
    input       nmi;
    input [6:0] req;
    begin
      if (nmi)
      begin
        pick_vector = `VEC_WATCHDOG;                     // RULE5
      end
      else if (req[0])
      begin
        pick_vector = `VEC_RF_CONV;
      end
      else if (req[1])
      begin
        pick_vector = `VEC_PTIMER;
      end
      else if (req[2])
      begin
        pick_vector = `VEC_SERIAL;
      end
      else if (req[3])
      begin
        pick_vector = `VEC_KEYS_LO;
      end
      else if (req[4])
      begin
        pick_vector = `VEC_KEYS_HI;
      end
      else if (req[5])
      begin
        pick_vector = `VEC_CLOCK;
      end
      else
      begin
        pick_vector = `VEC_STOPWATCH;
      end
    end
  endfunction

  // Unused bit positions of each group are tied low so they read as zero.
  assign evt[0] = {2'b00, rf_conv_evt};                  // RULE14
  assign evt[1] = {1'b0, ptimer_zero_evt};               // RULE9
  assign evt[2] = {3'b000, serial_done_evt};             // RULE10
  assign evt[3] = {3'b000, key_group0_evt};              // RULE11
  assign evt[4] = {3'b000, key_group1_evt};              // RULE11
  assign evt[5] = clock_timer_evt;                       // RULE12
  assign evt[6] = stopwatch_evt;                         // RULE13

  // The printed offsets are not all word aligned, so each one is a register
  // index and the byte address on the bus is four times it.
  wire [15:0] idx = paddr[17:2];
  wire        en_range = (idx >= `IDX_PTIMER_EN) && (idx <= `IDX_RF_CONV_EN);
  wire        pd_range = (idx >= `IDX_PTIMER_PEND) &&
                         (idx <= `IDX_RF_CONV_PEND);
  assign sel_ctl  = (idx == `IDX_CPU_CTRL);
  assign sel_pend = pd_range;
  assign hit      = en_range || pd_range || sel_ctl;
  assign sel      = grp_of(idx[3:0]);
  // Writes land only in the access cycle; with clk_en low they are lost,
  // so software must not use the bus while the block is frozen.
  assign wr_en    = psel && penable && pwrite && clk_en;
  assign rd_en    = psel && !penable && !pwrite;
  // Read data is ready from the setup cycle on, so no wait state is ever
  // needed and pready is simply tied high.
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;
  assign prdata   = rdata_r;

  // A group requests while any pending bit is also enabled; the handler
  // reads the group's flag register to find the exact source.
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1)
    begin : grp
      assign grp_req[g] = |(pend_r[g] & en_r[g]);        // RULE24 RULE8
    end
  endgenerate

  // Every request, the watchdog one included, stays blocked until both
  // stack pointers are written, so a half-set stack is never used.
  assign sp_ok    = wide_sp_ok_r && nib_sp_ok_r;
  assign nmi_req  = watchdog_req && sp_ok;               // RULE5 RULE23
  assign irq_req  = (|grp_req) && ie_r && sp_ok;         // RULE2 RULE23
  assign wake_req = irq_req || nmi_req;                  // RULE22
  // Acceptance waits for an instruction boundary and for an idle
  // sequencer, so two acceptances never overlap.
  assign take     = (state_r == ST_IDLE) && instr_done &&
                    (nmi_req || irq_req);                // RULE15

  // Both flag registers and masks; set beats a same-cycle clear.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < 7; i = i + 1)
      begin
        en_r[i]   <= `RST_NIBBLE;                        // RULE7
        pend_r[i] <= `RST_NIBBLE;                        // RULE4
      end
    end
    else if (clk_en)
    begin
      for (i = 0; i < 7; i = i + 1)
      begin
        if (wr_en && en_range && sel == i[2:0])
        begin
          en_r[i] <= pwdata[3:0] & grp_bits(i[2:0]);     // RULE6 RULE21
        end
        // An event in the same cycle as a write-one clear keeps the flag,
        // so no event is lost to a late clear.
        pend_r[i] <= ((pend_r[i] &
                      ~((wr_en && sel_pend && sel == i[2:0]) ?
                        pwdata[3:0] : 4'h0)) |           // RULE3
                      evt[i]) & grp_bits(i[2:0]);        // RULE1 RULE21
      end
    end
  end

  // Stack-pointer gate: writing one pointer blocks until the other follows.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wide_sp_ok_r <= 1'b0;
      nib_sp_ok_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      // Writing both pointers at once leaves the pair complete.
      if (wide_sp_write && nibble_sp_write)
      begin
        wide_sp_ok_r <= 1'b1;
        nib_sp_ok_r  <= 1'b1;
      end
      // Rewriting one pointer of a complete pair closes the window again
      // until the other pointer follows.
      else if (wide_sp_write)
      begin
        wide_sp_ok_r <= 1'b1;                            // RULE23
        nib_sp_ok_r  <= sp_ok ? 1'b0 : nib_sp_ok_r;
      end
      else if (nibble_sp_write)
      begin
        nib_sp_ok_r  <= 1'b1;                            // RULE23
        wide_sp_ok_r <= sp_ok ? 1'b0 : wide_sp_ok_r;
      end
    end
  end

  // Acceptance sequence: save flags, clear enable, push, then vector.
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (take)
        begin
          state_nxt = ST_SAVE;
        end
      end
      ST_SAVE:
      begin
        state_nxt = ST_PUSH;
      end
      ST_PUSH:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r       <= ST_IDLE;
      vector_addr_r <= `VEC_WATCHDOG;
      irq_take_r    <= 1'b0;
      flags_save_r  <= 1'b0;
      push_pc_r     <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r      <= state_nxt;
      // The three strobes follow one another, one cycle each: save the
      // flags, push the return address, then load the vector.
      flags_save_r <= take;                              // RULE16
      push_pc_r    <= (state_r == ST_SAVE);              // RULE17
      irq_take_r   <= (state_r == ST_PUSH);              // RULE18
      if (take)
      begin
        // Chosen once, at acceptance, so the vector cannot move while the
        // core is still saving state, even if a higher source arrives.
        vector_addr_r <= pick_vector(nmi_req, grp_req);  // RULE19 RULE25
      end
    end
  end

  // CPU interrupt-enable flag. Acceptance wins over a same-cycle software
  // write, so a handler never starts with maskable requests enabled.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ie_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_r == ST_SAVE)
      begin
        ie_r <= 1'b0;                                    // RULE16
      end
      else if (wr_en && sel_ctl)
      begin
        ie_r <= pwdata[`CTL_IE_BIT];
      end
    end
  end

  // Read data is captured in the setup cycle and held until the next read
  // setup, so the access phase needs no wait state.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_r <= 32'h0;
    end
    else if (clk_en && rd_en)
    begin
      if (en_range)
      begin
        rdata_r <= {28'h0, en_r[sel]};                   // RULE6
      end
      else if (pd_range)
      begin
        rdata_r <= {28'h0, pend_r[sel]};                 // RULE3
      end
      else if (sel_ctl)
      begin
        rdata_r <= {29'h0, nib_sp_ok_r, wide_sp_ok_r, ie_r};
      end
      else
      begin
        // Unmapped reads return zero alongside the slave error.
        rdata_r <= 32'h0;
      end
    end
  end

endmodule

// ===== verilog/irq_ctrl_map.vh
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH
// Register indices. The offsets are not all word aligned, so each is kept
// as an index and the APB byte address is four times the index.
`define IDX_PTIMER_EN     16'hFFE1
`define IDX_SERIAL_EN     16'hFFE2
`define IDX_KEYS_LO_EN    16'hFFE3
`define IDX_KEYS_HI_EN    16'hFFE4
`define IDX_CLOCK_EN      16'hFFE5
`define IDX_STOPWATCH_EN  16'hFFE6
`define IDX_RF_CONV_EN    16'hFFE7
`define IDX_PTIMER_PEND   16'hFFF1
`define IDX_SERIAL_PEND   16'hFFF2
`define IDX_KEYS_LO_PEND  16'hFFF3
`define IDX_KEYS_HI_PEND  16'hFFF4
`define IDX_CLOCK_PEND    16'hFFF5
`define IDX_STOPWATCH_PEND 16'hFFF6
`define IDX_RF_CONV_PEND  16'hFFF7
`define IDX_CPU_CTRL      16'hFFF8
// Implemented-bit masks per group (unimplemented bits read 0).
`define BITS_PTIMER       4'h7
`define BITS_SERIAL       4'h1
`define BITS_KEYS         4'h1
`define BITS_CLOCK        4'hF
`define BITS_STOPWATCH    4'hF
`define BITS_RF_CONV      4'h3
`define RST_NIBBLE        4'h0
// Control register bits.
`define CTL_IE_BIT        0
`define CTL_WIDE_SP_BIT   1
`define CTL_NIB_SP_BIT    2
// Vector addresses.
`define VEC_WATCHDOG      16'h0100
`define VEC_RF_CONV       16'h0102
`define VEC_PTIMER        16'h0104
`define VEC_SERIAL        16'h0106
`define VEC_KEYS_LO       16'h0108
`define VEC_KEYS_HI       16'h010A
`define VEC_CLOCK         16'h010C
`define VEC_STOPWATCH     16'h010E
`endif

// ===== dv/pic_checker_assertions.sv
`include "irq_ctrl_map.vh"
module pic_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire        watchdog_req,
  input wire        instr_done,
  input wire        irq_req,
  input wire        nmi_req,
  input wire        wake_req,
  input wire [15:0] vector_addr_r,
  input wire        irq_take_r,
  input wire        flags_save_r,
  input wire        push_pc_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wake_any_a: assert property (wake_req == (irq_req | nmi_req))
    else $error("wake request differs from the request pair");
  nmi_source_a: assert property (nmi_req |-> watchdog_req)
    else $error("nmi request without watchdog request");
  accept_order_a:
    assert property (flags_save_r |=> push_pc_r ##1 irq_take_r)
    else $error("acceptance steps out of order");
  accept_cause_a:
    assert property ($rose(flags_save_r) |-> $past(instr_done && wake_req))
    else $error("acceptance without finished instruction");
  ie_cleared_a: assert property (push_pc_r |-> !irq_req)
    else $error("maskable request still up after acceptance");
  vector_range_a:
    assert property (irq_take_r |-> vector_addr_r[15:4] == 12'h010 &&
                     !vector_addr_r[0])
    else $error("vector outside the table");
  wdog_first_a:
    assert property (irq_take_r && $past(nmi_req, 3) |->
                     vector_addr_r == `VEC_WATCHDOG)
    else $error("watchdog did not win priority");
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  cover property (irq_take_r && vector_addr_r == `VEC_WATCHDOG);
  cover property (irq_take_r && vector_addr_r == `VEC_STOPWATCH);
  cover property (pslverr);
endmodule

// ===== dv/cpu_core_model.sv
module cpu_core_model (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         irq_take_r,
  input  wire  [15:0] vector_addr_r,
  output logic        instr_done,
  output logic [15:0] last_vec,
  output logic [7:0]  takes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  // Three-cycle instructions make acceptance wait for the boundary.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ph <= 2'h0;
      instr_done <= 1'b0;
      last_vec <= 16'h0;
      takes <= 8'h0;
    end
    else
    begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      instr_done <= (ph == 2'h1);
      if (irq_take_r)
      begin
        last_vec <= vector_addr_r;
        takes <= takes + 8'h1;
      end
    end
endmodule

// ===== dv/peripheral_interrupt_controller_tb.sv
`include "irq_ctrl_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); num_errors++; end end
module peripheral_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] evt = 16'h0;
  logic        watchdog_req = 1'b0;
  logic        wide_sp_write = 1'b0;
  logic        nibble_sp_write = 1'b0;
  logic [31:0] rd;
  logic        err;
  wire  [2:0]  ptimer_zero_evt;
  wire  [3:0]  clock_timer_evt, stopwatch_evt;
  wire  [1:0]  rf_conv_evt;
  wire         serial_done_evt, key_group0_evt, key_group1_evt;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_req, nmi_req, wake_req, instr_done;
  wire  [15:0] vector_addr_r, last_vec;
  wire         irq_take_r, flags_save_r, push_pc_r;
  wire  [7:0]  takes;
  int          num_errors = 0;
  int          samples_checked = 0;
  localparam logic [15:0] PEND [7] = '{`IDX_RF_CONV_PEND, `IDX_PTIMER_PEND,
    `IDX_SERIAL_PEND, `IDX_KEYS_LO_PEND, `IDX_KEYS_HI_PEND,
    `IDX_CLOCK_PEND, `IDX_STOPWATCH_PEND};
  localparam logic [3:0] BITS [7] = '{`BITS_RF_CONV, `BITS_PTIMER,
    `BITS_SERIAL, `BITS_KEYS, `BITS_KEYS, `BITS_CLOCK, `BITS_STOPWATCH};
  assign {ptimer_zero_evt, serial_done_evt, key_group0_evt, key_group1_evt,
          clock_timer_evt, stopwatch_evt, rf_conv_evt} = evt;
  peripheral_interrupt_controller u_dut (.*);
  cpu_core_model u_cpu (.*);
  always #5 pclk = ~pclk;
  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] i,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      num_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sp(input logic [1:0] s);
    @(posedge pclk);
    {wide_sp_write, nibble_sp_write} <= s;
    @(posedge pclk);
    {wide_sp_write, nibble_sp_write} <= 2'b00;
  endtask
  task automatic wait_take(input logic [7:0] n0);
    int n;
    n = 0;
    while (takes === n0 && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    if (takes === n0)
    begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic t_reset;
    for (int g = 0; g < 7; g++)
    begin
      apb(1'b0, PEND[g], 32'h0);
      `CHK("pend_rst", 32'h0, rd)
      apb(1'b0, PEND[g] - 16'h10, 32'h0);
      `CHK("mask_rst", 32'h0, rd)
    end
    apb(1'b0, 16'h0123, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask
  task automatic t_events;
    @(posedge pclk);
    clk_en <= 1'b0;
    evt <= 16'hFFFF;
    @(posedge pclk);
    clk_en <= 1'b1;
    evt <= 16'h0;
    apb(1'b0, PEND[6], 32'h0);
    `CHK("frozen", 32'h0, rd)
    @(posedge pclk);
    evt <= 16'hFFFF;
    @(posedge pclk);
    evt <= 16'h0;
    for (int g = 0; g < 7; g++)
    begin
      apb(1'b0, PEND[g], 32'h0);
      `CHK("pend", {28'h0, BITS[g]}, rd)
      `CHK("masked", 1'b0, irq_req)
    end
    apb(1'b1, PEND[0], 32'h0);
    apb(1'b0, PEND[0], 32'h0);
    `CHK("w0_keep", 32'h3, rd)
    apb(1'b1, PEND[0], 32'h1);
    apb(1'b0, PEND[0], 32'h0);
    `CHK("w1_clear", 32'h2, rd)
    for (int g = 0; g < 7; g++)
    begin
      apb(1'b1, PEND[g] - 16'h10, 32'hFFFFFFFF);
      apb(1'b0, PEND[g] - 16'h10, 32'h0);
      `CHK("mask_rw", {28'h0, BITS[g]}, rd)
    end
  endtask
  task automatic t_prio;
    logic [7:0] n0;
    for (int g = 0; g < 7; g++)
    begin
      n0 = takes;
      apb(1'b1, `IDX_CPU_CTRL, 32'h1);
      if (g == 0)
      begin
        `CHK("sp_block", 1'b0, irq_req)
        sp(2'b11);
      end
      wait_take(n0);
      `CHK("vector", 16'h0102 + 16'(2 * g), last_vec)
      apb(1'b1, PEND[g], 32'hF);
    end
    apb(1'b1, `IDX_CPU_CTRL, 32'h1);
    @(negedge pclk);
    `CHK("all_clear", 1'b0, irq_req)
  endtask
  task automatic t_nmi;
    logic [7:0] n0;
    @(posedge pclk);
    n0 = takes;
    watchdog_req <= 1'b1;
    wait_take(n0);
    `CHK("nmi_vec", `VEC_WATCHDOG, last_vec)
    sp(2'b10);
    @(negedge pclk);
    `CHK("nmi_block", 1'b0, nmi_req)
    sp(2'b01);
    @(negedge pclk);
    `CHK("nmi_wake", 1'b1, wake_req)
    @(posedge pclk);
    watchdog_req <= 1'b0;
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_prio();
    t_nmi();
    close_out();
  end
endmodule
bind peripheral_interrupt_controller pic_checker u_chk (.*);
